/* core/csfr_regs.v */
// CPU special-function register bank: PC low, table, status, bank, option map.
`timescale 1ns/100ps
`include "csfr_consts.vh"
module csfr_regs #(
    parameter PC_W = 11,
    parameter MAP_TICKS = 4
) (
    input wire ref_clk,
    input wire rst_b,
    // Power-up reset marker; rst_b alone is a watchdog reset
    input wire power_up,
    input wire wdt_reset_asleep,
    // Register access from the instruction stream
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire direct_mode,
    output reg [7:0] rdata,
    output reg phys_bank,
    // ALU flag update
    input wire [2:0] alu_op,
    input wire [7:0] alu_a,
    input wire [7:0] alu_b,
    input wire alu_cin,
    output reg [7:0] alu_res,
    // System events
    input wire wdt_timeout,
    input wire watchdog_clear_instr_instr,
    input wire sleep_instr,
    input wire wake_up,
    // Jumps by writing PC low
    input wire [PC_W-1:0] pc_now,
    output reg jump_valid,
    output reg [PC_W-1:0] jump_target,
    output reg dummy_cycle,
    // Table read
    input wire table_read,
    input wire last_page_form,
    input wire [15:0] prog_word,
    input wire [15:0] opt_word,
    output reg [PC_W-1:0] table_addr,
    output reg [7:0] table_low,
    output reg table_low_valid,
    // Option mapping
    input wire slow_internal_osc,
    output reg map_active,
    output reg [7:0] status_out,
    output reg [7:0] table_read_high_byte
);
    // *****************************************
    // Storage
    // *****************************************
    reg [7:0] table_pointer_low;
    reg [7:0] table_pointer_high;
    reg [7:0] option_map_unlock;
    reg bank_select_bit;
    reg c_f, ac_f, z_f, ov_f;
    reg powerdown_flag;
    reg watchdog_expired_flag;
    reg key_armed;
    reg [2:0] map_cnt;
    wire slow_rise;
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] low7;
    reg cin7;
    reg next_c, next_ac, next_z, next_ov;
    reg [7:0] next_res;
    reg [PC_W-1:0] next_taddr;
    wire [PC_W-1:0] last_page;

    // *****************************************
    // Derived constants
    // *****************************************
    // Counter compare value; kept 32 bits wide and sliced on use
    localparam [31:0] MAP_LAST = MAP_TICKS - 1;
    // Data EEPROM is 32 bytes; this module has no EEPROM ports
    localparam [31:0] EE_BYTES = `CSFR_EE_BYTES;

    assign last_page = {{(PC_W-8){1'b1}}, 8'h00};

    csfr_edge_det u_slow (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .sig_in(slow_internal_osc),
        .rise(slow_rise)
    );

    // *****************************************
    // ALU flag generation
    // *****************************************
    // Subtraction uses a + ~b + 1 so carry means no borrow
    always @* begin
        sum = 9'h000;
        nib = 5'h00;
        low7 = 8'h00;
        cin7 = 1'b0;
        next_res = 8'h00;
        next_c = c_f;
        next_ac = ac_f;
        next_z = z_f;
        next_ov = ov_f;
        case (alu_op)
            `CSFR_OP_ADD, `CSFR_OP_SUB: begin
                if (alu_op == `CSFR_OP_ADD) begin
                    sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
                    nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
                    low7 = {1'b0, alu_a[6:0]} + {1'b0, alu_b[6:0]} + {7'h00, alu_cin};
                end else begin
                    sum = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
                    nib = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
                    low7 = {1'b0, alu_a[6:0]} + {1'b0, ~alu_b[6:0]} + 8'h01;
                end
                cin7 = low7[7];
                next_res = sum[7:0];
                next_c = sum[8];
                next_ac = nib[4];
                next_z = (sum[7:0] == 8'h00);
                next_ov = cin7 ^ sum[8];
            end
            `CSFR_OP_LOGIC: begin
                next_res = alu_a;
                next_z = (alu_a == 8'h00);
            end
            `CSFR_OP_RLC: begin
                next_res = {alu_a[6:0], c_f};
                next_c = alu_a[7];
            end
            `CSFR_OP_RRC: begin
                next_res = {c_f, alu_a[7:1]};
                next_c = alu_a[0];
            end
            default: begin
                next_res = 8'h00;
            end
        endcase
    end

    // *****************************************
    // Table address: last-page form fixes the page, other form uses high pointer
    // *****************************************
    always @* begin
        if (last_page_form) begin
            next_taddr = last_page | {{(PC_W-8){1'b0}}, table_pointer_low};
        end else begin
            // Software must aim high pointer at last page here
            next_taddr = {table_pointer_high[PC_W-9:0], table_pointer_low};
        end
    end

    // *****************************************
    // Main register process
    // *****************************************
    // Status is never stacked here; software saves it
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            table_pointer_low <= `CSFR_RST_BYTE;
            table_pointer_high <= `CSFR_RST_BYTE;
            table_read_high_byte <= `CSFR_RST_BYTE;
            option_map_unlock <= `CSFR_RST_BYTE;
            key_armed <= 1'b0;
            map_cnt <= 3'h0;
            map_active <= 1'b0;
            // Arithmetic flags are undefined; zero chosen for determinism
            {c_f, ac_f, z_f, ov_f} <= 4'h0;
            if (power_up) begin
                powerdown_flag <= 1'b0;
                watchdog_expired_flag <= 1'b0;
            end else begin
                // Watchdog reset marks the expiry
                watchdog_expired_flag <= 1'b1;
            end
            if (power_up || !wdt_reset_asleep) begin
                bank_select_bit <= 1'b0;
            end
            jump_valid <= 1'b0;
            jump_target <= {PC_W{1'b0}};
            dummy_cycle <= 1'b0;
            table_addr <= {PC_W{1'b0}};
            table_low <= 8'h00;
            table_low_valid <= 1'b0;
            rdata <= 8'h00;
            phys_bank <= 1'b0;
            alu_res <= 8'h00;
            status_out <= 8'h00;
        end else begin
            jump_valid <= 1'b0;
            dummy_cycle <= jump_valid;
            table_low_valid <= 1'b0;
            alu_res <= next_res;
            {c_f, ac_f, z_f, ov_f} <= {next_c, next_ac, next_z, next_ov};
            // Direct accesses stay in bank 0
            phys_bank <= direct_mode ? 1'b0 : bank_select_bit;

            // *****************************************
            // System flags
            // *****************************************
            // Set wins over clear when both land together
            // Software writes cannot reach these two bits; reads see them
            if (watchdog_clear_instr_instr || sleep_instr) begin
                watchdog_expired_flag <= 1'b0;
            end
            if (wdt_timeout) begin
                watchdog_expired_flag <= 1'b1;
            end
            if (watchdog_clear_instr_instr) begin
                powerdown_flag <= 1'b0;
            end
            if (sleep_instr) begin
                powerdown_flag <= 1'b1;
            end

            // *****************************************
            // Option mapping timer
            // *****************************************
            // Unlock timer counts slow oscillator edges
            if (map_active && slow_rise) begin
                if (map_cnt == MAP_LAST[2:0]) begin
                    map_active <= 1'b0;
                    map_cnt <= 3'h0;
                end else begin
                    map_cnt <= map_cnt + 3'h1;
                end
            end

            // *****************************************
            // Register writes
            // *****************************************
            // Arm lasts one cycle only
            key_armed <= 1'b0;
            if (wr_en) begin
                case (addr)
                    `CSFR_A_PCL: begin
                        // Only the low byte moves, so the jump stays in page
                        jump_valid <= 1'b1;
                        jump_target <= {pc_now[PC_W-1:8], wdata};
                    end
                    `CSFR_A_TABLE_POINTER_LOW: table_pointer_low <= wdata;
                    `CSFR_A_TABLE_POINTER_HIGH: table_pointer_high <= wdata;
                    `CSFR_A_TABLE_READ_HIGH_BYTE: table_read_high_byte <= wdata;
                    `CSFR_A_STATUS: begin
                        // Only arithmetic flags take the write
                        c_f <= wdata[`CSFR_B_C];
                        ac_f <= wdata[`CSFR_B_AC];
                        z_f <= wdata[`CSFR_B_Z];
                        ov_f <= wdata[`CSFR_B_OV];
                    end
                    `CSFR_A_BANK: bank_select_bit <= wdata[0];
                    `CSFR_A_UNLOCK: begin
                        option_map_unlock <= wdata;
                        key_armed <= (wdata == `CSFR_KEY1);
                        if (key_armed && wdata == `CSFR_KEY2) begin
                            map_active <= 1'b1;
                            map_cnt <= 3'h0;
                        end
                    end
                    // Indirect ports hold nothing
                    default: begin
                    end
                endcase
            end
            if (wake_up) begin
                option_map_unlock <= `CSFR_RST_BYTE;
            end

            // *****************************************
            // Table read
            // *****************************************
            // Mapped window returns option words
            if (table_read) begin
                table_addr <= next_taddr;
                table_low_valid <= 1'b1;
                if (map_active && next_taddr[PC_W-1:8] == last_page[PC_W-1:8]
                        && next_taddr[7:0] >= `CSFR_OPT_BASE) begin
                    table_read_high_byte <= opt_word[15:8];
                    table_low <= opt_word[7:0];
                end else begin
                    table_read_high_byte <= prog_word[15:8];
                    table_low <= prog_word[7:0];
                end
            end

            // *****************************************
            // Register readback
            // *****************************************
            // PC low reads the live counter, not a stored copy
            if (rd_en) begin
                case (addr)
                    `CSFR_A_PCL: rdata <= pc_now[7:0];
                    `CSFR_A_TABLE_POINTER_LOW: rdata <= table_pointer_low;
                    `CSFR_A_TABLE_POINTER_HIGH: rdata <= table_pointer_high;
                    `CSFR_A_TABLE_READ_HIGH_BYTE: rdata <= table_read_high_byte;
                    `CSFR_A_STATUS: rdata <= {2'b00, watchdog_expired_flag,
                        powerdown_flag, ov_f, z_f, ac_f, c_f};
                    `CSFR_A_BANK: rdata <= {7'h00, bank_select_bit};
                    `CSFR_A_UNLOCK: rdata <= option_map_unlock;
                    default: rdata <= 8'h00;
                endcase
            end
            status_out <= {2'b00, watchdog_expired_flag, powerdown_flag,
                ov_f, z_f, ac_f, c_f};
        end
    end
endmodule

/* core/csfr_consts.vh */
// Constants for the CPU special-function register block.
// Operation
// - PC low write jumps within page, dummy cycle
// - Table read: high byte kept, low to destination
// - Status writes leave watchdog and powerdown flags
// - Watchdog flag: set timeout, clear clrwdt/sleep/power-up
// - Powerdown flag: set sleep, clear clrwdt/power-up
// - Carry from add, no-borrow subtract, rotates
// - Nibble carry from low nibble add/sub
// - Zero flag when result equals zero
// - Signed range: carry in xor carry out
// - Status never saved automatically on call/interrupt
// - Status bits 7,6 zero; system flags zero after power-up reset
// - Bank bit selects bank; bits 7..1 zero
// - Resets clear bank except watchdog reset asleep
// - Direct addressing always reaches bank 0
// - Unlock needs 55H then AAH consecutively
// - Mapping shows option memory at E0H onward
// - Mapping ends after four slow oscillator periods
// - Each further unlock restarts mapping timer
// - Unlock register cleared on wake, zero at reset
// - Data EEPROM is 32 bytes, byte access only
// - Indirect ports read zero, write acts elsewhere
`ifndef CSFR_CONSTS_VH
`define CSFR_CONSTS_VH
// Register addresses in special data space
`define CSFR_A_INDIRECT_ACCESS_PORT_A 8'h00
`define CSFR_A_INDIRECT_ACCESS_PORT_B 8'h02
`define CSFR_A_PCL 8'h06
`define CSFR_A_TABLE_POINTER_LOW 8'h07
`define CSFR_A_TABLE_READ_HIGH_BYTE 8'h08
`define CSFR_A_TABLE_POINTER_HIGH 8'h09
`define CSFR_A_STATUS 8'h0A
`define CSFR_A_BANK 8'h04
`define CSFR_A_UNLOCK 8'h5F
// Status field positions
`define CSFR_B_C 0
`define CSFR_B_AC 1
`define CSFR_B_Z 2
`define CSFR_B_OV 3
`define CSFR_B_PDF 4
`define CSFR_B_TO 5
// Reset values and patterns
`define CSFR_RST_BYTE 8'h00
`define CSFR_KEY1 8'h55
`define CSFR_KEY2 8'hAA
`define CSFR_OPT_BASE 8'hE0
`define CSFR_OPT_WORDS 32
`define CSFR_EE_BYTES 32
`define CSFR_MAP_TICKS 3'h4
// ALU operation codes
`define CSFR_OP_NONE 3'h0
`define CSFR_OP_ADD 3'h1
`define CSFR_OP_SUB 3'h2
`define CSFR_OP_LOGIC 3'h3
`define CSFR_OP_RLC 3'h4
`define CSFR_OP_RRC 3'h5
`endif

/* core/csfr_edge_det.v */
// Rising-edge detector for the slow oscillator input.
`timescale 1ns/100ps
module csfr_edge_det (
    input wire ref_clk,
    input wire rst_b,
    input wire sig_in,
    output reg rise
);
    reg last;
    // Input already synchronous; one stage of history is enough
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            last <= 1'b0;
            rise <= 1'b0;
        end else begin
            last <= sig_in;
            rise <= sig_in & ~last;
        end
    end
endmodule

/* tb/csfr_regs_checker.sv */
// Assertion checker bound to the special-function register bank.
`timescale 1ns/100ps
`include "csfr_consts.vh"
module csfr_regs_checker #(
    parameter PC_W = 11
) (
    input wire ref_clk,
    input wire rst_b,
    input wire wr_en,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wdt_timeout,
    input wire watchdog_clear_instr_instr,
    input wire sleep_instr,
    input wire wake_up,
    input wire [PC_W-1:0] pc_now,
    input wire jump_valid,
    input wire [PC_W-1:0] jump_target,
    input wire dummy_cycle,
    input wire map_active,
    input wire [7:0] status_out
);
    // ************************************************************
    // Port relations
    // ************************************************************
    logic key1_seen;
    // First unlock key seen last cycle; reset gating drops stale keys
    always_ff @(posedge ref_clk) begin
        key1_seen <= rst_b && wr_en && addr == `CSFR_A_UNLOCK && wdata == `CSFR_KEY1 && !wake_up;
    end
    // One clock domain, so clocking and reset are set once
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Flags show on status_out two edges after their cause
    a_jump_in_page: assert property (wr_en && addr == `CSFR_A_PCL |=> jump_valid &&
        jump_target[7:0] == $past(wdata) && (jump_target >> 8) == ($past(pc_now) >> 8))
        else $error("jump strobe or target wrong after pc low write");
    a_dummy_follows: assert property (jump_valid |=> dummy_cycle)
        else $error("no dummy cycle after jump");
    a_sysflag_kept: assert property (wr_en && addr == `CSFR_A_STATUS && !wdt_timeout &&
        !watchdog_clear_instr_instr && !sleep_instr |-> ##2 status_out[5:4] == $past(status_out[5:4]))
        else $error("status write changed system flags");
    a_top_bits_zero: assert property (status_out[7:6] == 2'b00)
        else $error("status top bits not zero");
    a_sleep_flags: assert property (sleep_instr && !wdt_timeout && !watchdog_clear_instr_instr
        |-> ##2 status_out[5:4] == 2'b01) else $error("sleep entry flags wrong");
    a_timeout_flag: assert property (wdt_timeout |-> ##2 status_out[5])
        else $error("timeout did not set watchdog flag");
    a_clear_flags: assert property (watchdog_clear_instr_instr && !wdt_timeout && !sleep_instr
        |-> ##2 status_out[5:4] == 2'b00) else $error("watchdog clear left flags set");
    a_unlock_maps: assert property (key1_seen && wr_en && addr == `CSFR_A_UNLOCK &&
        wdata == `CSFR_KEY2 && !wake_up |=> map_active) else $error("unlock did not map");
endmodule

bind csfr_regs csfr_regs_checker #(.PC_W(PC_W)) i_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .wr_en(wr_en), .addr(addr), .wdata(wdata),
    .wdt_timeout(wdt_timeout), .watchdog_clear_instr_instr(watchdog_clear_instr_instr), .sleep_instr(sleep_instr),
    .wake_up(wake_up), .pc_now(pc_now), .jump_valid(jump_valid), .jump_target(jump_target),
    .dummy_cycle(dummy_cycle), .map_active(map_active), .status_out(status_out)
);

/* tb/tb.sv */
// Self-checking bench for the special-function register bank.
`timescale 1ns/100ps
`include "csfr_consts.vh"
module tb;
    logic ref_clk, rst_b, power_up, wdt_reset_asleep, wr_en, rd_en, direct_mode, alu_cin;
    logic wdt_timeout, watchdog_clear_instr_instr, sleep_instr, wake_up, table_read, last_page_form;
    logic slow_internal_osc, phys_bank, jump_valid, dummy_cycle, table_low_valid, map_active;
    logic [7:0] addr, wdata, alu_a, alu_b, rdata, alu_res, table_low, status_out;
    logic [7:0] table_read_high_byte;
    logic [2:0] alu_op;
    logic [10:0] pc_now, jump_target, table_addr;
    logic [15:0] prog_word, opt_word;
    int bad_count = 0;
    int check_count = 0;
    csfr_regs #(.PC_W(11), .MAP_TICKS(4)) i_dut (.*);
    // ************************************************************
    // Clock, helpers and scenarios
    // ************************************************************
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    task results;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Inputs move 1 ns after the edge so sampling never races
    task tk;
        @(posedge ref_clk);
        #1;
    endtask
    task idle;
        wr_en = 0;
        tk;
    endtask
    // Leaves wr_en high so two writes land in consecutive cycles
    task wr(input [7:0] a, input [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1;
        tk;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        wr_en = 0;
        rd_en = 1;
        addr = a;
        tk;
        rd_en = 0;
        chk(rdata, e);
        tk;
    endtask
    task alu(input [2:0] op, input [7:0] a, input [7:0] r, input [7:0] f, input [7:0] m);
        alu_op = op;
        alu_a = a;
        alu_b = 8'h01;
        tk;
        alu_op = `CSFR_OP_NONE;
        chk(alu_res, r);
        tk;
        chk(status_out & m, f);
    endtask
    task tbl(input lp, input [10:0] ta, input [15:0] e);
        last_page_form = lp;
        table_read = 1;
        tk;
        table_read = 0;
        chk({table_low_valid, table_addr, table_read_high_byte, table_low}, {1'b1, ta, e});
    endtask
    task osc(input int n);
        repeat (n) begin
            slow_internal_osc = 1;
            repeat (4) tk;
            slow_internal_osc = 0;
            repeat (4) tk;
        end
    endtask
    task t_flags;
        sleep_instr = 1;
        idle;
        sleep_instr = 0;
        tk;
        chk(status_out, 8'h10);
        wdt_timeout = 1;
        tk;
        wdt_timeout = 0;
        tk;
        chk(status_out, 8'h30);
        wr(`CSFR_A_STATUS, 8'hFF);
        idle;
        chk(status_out, 8'h3F);
        watchdog_clear_instr_instr = 1;
        tk;
        watchdog_clear_instr_instr = 0;
        tk;
        chk(status_out, 8'h0F);
        alu(`CSFR_OP_ADD, 8'h7F, 8'h80, 8'h0A, 8'h0F);
        alu(`CSFR_OP_ADD, 8'hFF, 8'h00, 8'h07, 8'h0F);
        alu(`CSFR_OP_SUB, 8'h01, 8'h00, 8'h07, 8'h0F);
        alu(`CSFR_OP_SUB, 8'h00, 8'hFF, 8'h00, 8'h0F);
        alu(`CSFR_OP_LOGIC, 8'h00, 8'h00, 8'h04, 8'h04);
        alu(`CSFR_OP_RLC, 8'h81, 8'h02, 8'h01, 8'h01);
        alu(`CSFR_OP_RRC, 8'h02, 8'h81, 8'h00, 8'h01);
    endtask
    task t_jump;
        pc_now = 11'h5A3;
        wr(`CSFR_A_PCL, 8'h3C);
        wr_en = 0;
        chk({jump_valid, jump_target}, {1'b1, 11'h53C});
        tk;
        chk({jump_valid, dummy_cycle}, 2'b01);
        tbl(0, 11'h000, 16'hBEEF);
        rd(`CSFR_A_TABLE_READ_HIGH_BYTE, 8'hBE);
    endtask
    task t_unlock;
        wr(`CSFR_A_UNLOCK, 8'h55);
        wr(`CSFR_A_UNLOCK, 8'h12);
        wr(`CSFR_A_UNLOCK, 8'hAA);
        idle;
        wr(`CSFR_A_UNLOCK, 8'h55);
        idle;
        wr(`CSFR_A_UNLOCK, 8'hAA);
        idle;
        chk(map_active, 0);
        // Wake clears on its edge; read back one cycle later
        wake_up = 1;
        idle;
        wake_up = 0;
        rd(`CSFR_A_UNLOCK, 8'h00);
        // Back-to-back writes, nothing can slip in between
        wr(`CSFR_A_UNLOCK, 8'h55);
        wr(`CSFR_A_UNLOCK, 8'hAA);
        wr(`CSFR_A_TABLE_POINTER_LOW, 8'hE3);
        idle;
        chk(map_active, 1);
        tbl(1, 11'h7E3, 16'h1234);
        wr(`CSFR_A_TABLE_POINTER_HIGH, 8'h07);
        idle;
        tbl(0, 11'h7E3, 16'h1234);
        osc(3);
        chk(map_active, 1);
        wr(`CSFR_A_UNLOCK, 8'h55);
        wr(`CSFR_A_UNLOCK, 8'hAA);
        idle;
        osc(3);
        chk(map_active, 1);
        osc(1);
        chk(map_active, 0);
    endtask
    task t_bank;
        wr(`CSFR_A_BANK, 8'hFF);
        rd(`CSFR_A_BANK, 8'h01);
        rd(8'h3F, 8'h00);
        direct_mode = 1;
        rd(`CSFR_A_INDIRECT_ACCESS_PORT_B, 8'h00);
        chk(phys_bank, 0);
        direct_mode = 0;
        rd(`CSFR_A_INDIRECT_ACCESS_PORT_A, 8'h00);
        chk(phys_bank, 1);
        rst_b = 0;
        power_up = 0;
        wdt_reset_asleep = 1;
        tk;
        rst_b = 1;
        rd(`CSFR_A_BANK, 8'h01);
        rd(`CSFR_A_STATUS, 8'h20);
        rst_b = 0;
        wdt_reset_asleep = 0;
        tk;
        rst_b = 1;
        rd(`CSFR_A_BANK, 8'h00);
    endtask
    // Main sequence: power-up reset, then each scenario in turn
    initial begin
        {rst_b, wdt_reset_asleep, wr_en, rd_en, direct_mode, alu_cin, wdt_timeout} = '0;
        {watchdog_clear_instr_instr, sleep_instr, wake_up, table_read, last_page_form} = '0;
        {slow_internal_osc, addr, wdata, alu_a, alu_b, alu_op, pc_now} = '0;
        prog_word = 16'hBEEF;
        opt_word = 16'h1234;
        power_up = 1;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_b = 1;
        rd(`CSFR_A_STATUS, 8'h00);
        rd(`CSFR_A_UNLOCK, 8'h00);
        t_flags;
        t_jump;
        t_unlock;
        t_bank;
        results;
    end
    // Hang guard, far beyond the roughly 130 cycles the run needs
    initial begin
        #20000;
        bad_count++;
        results;
    end
endmodule
